// ==== verilog/shp_pkg.sv ====
// Summary of operation
// - each channel holds 16 write registers plus a transmit buffer for its configuration.
// - data/control select high goes straight to transmit or receive buffer.
// - control write carries a three-bit pointer; the next access uses that register.
// - pointer clears itself after the pointed read or write completes.
// - every register, data registers included, is also reachable through the pointer.
// - ten read registers plus receive buffer; four of them return status.
// - two read registers return the programmed time constant low and high bytes.
// - vector reads plain through channel A, status-modified through channel B.
// - two read registers return the DMA FIFO contents.
// - pending-bits register in channel A shows all interrupt pending bits.
// - all special receive condition error flags read from one register.
// - vector and master interrupt control registers are shared by both channels.
// - strobes are synchronised into the clock domain before use.
// - an access is active only while chip select and strobe are both asserted.
// - daisy chains settle between acknowledge low and read strobe falling.
// - acknowledge cycle claimed only with pending interrupt and chain input high.
// - claimed acknowledge drives the vector on the data bus unless the no-vector bit is set, and sets under-service on the same clock.
// - read and write strobes low together for 250 ns reset the device.
// - primary status shows rx available, zero count, tx empty, dcd, hunt, cts, underrun, break.
// - loop/clock status shows on loop, loop sending, one and two clocks missing.
// - interrupt request pulled low when an enabled pending bit is set and chain input high.
// - a set under-service latch blocks lower sources and pulls chain output low.
`default_nettype none
package shp_pkg;
  localparam int CLK_NS = 10;
  localparam int RESET_LOW_NS = 250;
  localparam int RESET_CYC = (RESET_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_SPECIAL = 4'h1;
  localparam logic [3:0] REG_VECTOR = 4'h2;
  localparam logic [3:0] REG_PENDING = 4'h3;
  localparam logic [3:0] REG_FIFO_LO = 4'h6;
  localparam logic [3:0] REG_FIFO_HI = 4'h7;
  localparam logic [3:0] REG_DATA = 4'h8;
  localparam logic [3:0] REG_MASTER_INT = 4'h9;
  localparam logic [3:0] REG_LOOP_CLK = 4'ha;
  localparam logic [3:0] REG_TC_LO = 4'hc;
  localparam logic [3:0] REG_TC_HI = 4'hd;
  localparam logic [3:0] REG_EXT_EN = 4'hf;
  localparam int CMD_PTR_MSB = 2;
  localparam int CMD_CODE_LSB = 3;
  localparam logic [2:0] CMD_POINT_HIGH = 3'h1;
  localparam logic [2:0] CMD_RESET_IUS = 3'h7;
  localparam int MIC_MIE_BIT = 3;
  localparam int MIC_NV_BIT = 1;
  localparam int MIC_VIS_BIT = 0;
  localparam logic [2:0] NO_INT_CODE = 3'h3;
  localparam logic [7:0] WREG_RESET = 8'h00;
  localparam logic [3:0] PTR_RESET = 4'h0;
  localparam int NUM_SRC = 6;
  typedef struct packed {
    logic break_abort;
    logic tx_underrun;
    logic cts;
    logic sync_hunt;
    logic carrier_detect;
    logic tx_empty;
    logic zero_count;
    logic rx_avail;
  } shp_main_stat_t;
  typedef struct packed {
    logic one_clock_missing;
    logic two_clocks_missing;
    logic pad5;
    logic loop_sending;
    logic pad3;
    logic pad2;
    logic on_loop;
    logic pad0;
  } shp_loop_stat_t;
  typedef struct packed {
    shp_main_stat_t main;
    logic [7:0] special;
    shp_loop_stat_t loop;
    logic [7:0] rx_data;
    logic [7:0] fifo_lo;
    logic [7:0] fifo_hi;
  } shp_chan_in_t;
  typedef struct packed {
    logic valid;
    logic chan_a;
    logic [3:0] idx;
    logic [7:0] data;
  } shp_cfg_wr_t;
  typedef enum logic [3:0] {
    ACC_IDLE = 4'b0001,
    ACC_READ = 4'b0010,
    ACC_WRITE = 4'b0100,
    ACC_ACK = 4'b1000
  } shp_acc_t;
endpackage : shp_pkg
`default_nettype wire

// ==== verilog/shp_sync3.sv ====
`default_nettype none
module shp_sync3 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  if (W < 1)
  begin : g_bad_width
    $error("shp_sync3 width must be positive");
  end

  // a bit moves only once the second and third stage agree
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      q <= '0;
    end
    else
    begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      q <= (~(s2 ^ s3) & s3) | ((s2 ^ s3) & q);
    end
  end
endmodule : shp_sync3
`default_nettype wire

// ==== verilog/shp_host_port.sv ====
`default_nettype none
module shp_host_port #(
  parameter int RESET_CYCLES = shp_pkg::RESET_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic data_sel,
  input wire logic chan_a_sel,
  input wire logic interrupt_acknowledge_n,
  input wire logic priority_chain_in,
  output logic priority_chain_out,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic int_req_out,
  output logic int_req_oe,
  input wire shp_pkg::shp_chan_in_t chan_a_in,
  input wire shp_pkg::shp_chan_in_t chan_b_in,
  input wire logic [5:0] interrupt_pending_bit,
  output logic [1:0] tx_load,
  output logic [7:0] tx_data,
  output logic [1:0] rx_take,
  output shp_pkg::shp_cfg_wr_t cfg_wr,
  output logic hw_reset
);
  if (RESET_CYCLES < 1 || RESET_CYCLES > 255)
  begin : g_bad_reset_cycles
    $error("RESET_CYCLES out of range");
  end

  logic ce_s, rd_s, wr_s, dc_s, ab_s, ack_s, iei_s;
  logic [7:0] din_s;
  shp_pkg::shp_acc_t state;
  shp_pkg::shp_acc_t next_state;
  logic [3:0] ptr;
  logic dc_l;
  logic ch_a_l;
  logic [7:0] wdata;
  logic [7:0] wreg [2][16];
  logic [7:0] vec_reg;
  logic [7:0] mic_reg;
  logic [5:0] under_service_latch;
  logic [7:0] rst_cnt;
  logic srst;
  logic claim;

  // strobes, selects and data all cross from the bus side
  shp_sync3 #(.W(15)) u_sync (
    .clk(clk),
    .nrst(nrst),
    .d({~ce_n, ~rd_n, ~wr_n, data_sel, chan_a_sel, ~interrupt_acknowledge_n, priority_chain_in, data_in}),
    .q({ce_s, rd_s, wr_s, dc_s, ab_s, ack_s, iei_s, din_s})
  );

  logic both_low, rd_act, wr_act;
  assign both_low = rd_s & wr_s;
  assign rd_act = ce_s & rd_s & ~wr_s;
  assign wr_act = ce_s & wr_s & ~rd_s;

  function automatic logic [5:0] shp_gate(input logic [5:0] ip, input logic [5:0] us);
    logic blocked;
    logic [5:0] r;
    blocked = 1'b0;
    r = '0;
    for (int i = 5; i >= 0; i--)
    begin
      blocked = blocked | us[i];
      r[i] = ip[i] & ~blocked;
    end
    return r;
  endfunction : shp_gate

  function automatic logic [2:0] shp_top(input logic [5:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 0; i < 6; i++)
    begin
      if (v[i]) r = 3'(i);
    end
    return r;
  endfunction : shp_top

  // bit 5 is channel A receive, bit 0 channel B external/status
  function automatic logic [2:0] shp_code(input logic [5:0] v);
    logic [2:0] c;
    case (shp_top(v))
      3'h5: c = 3'h6;
      3'h4: c = 3'h4;
      3'h3: c = 3'h5;
      3'h2: c = 3'h2;
      3'h1: c = 3'h0;
      default: c = 3'h1;
    endcase
    if (v == 6'h00) c = shp_pkg::NO_INT_CODE;
    return c;
  endfunction : shp_code

  function automatic logic [7:0] shp_vec_mod(input logic [7:0] v, input logic [2:0] c);
    return {v[7:4], c, v[0]};
  endfunction : shp_vec_mod

  // interrupt chain, internal order fixed by bit position
  logic mie;
  logic [5:0] req_vec;
  logic req_any;
  assign mie = mic_reg[shp_pkg::MIC_MIE_BIT];
  assign req_vec = mie ? shp_gate(interrupt_pending_bit, under_service_latch) : 6'h00;
  assign req_any = |req_vec;
  assign int_req_out = 1'b0;
  assign int_req_oe = req_any & iei_s;
  assign priority_chain_out = iei_s & ~(|under_service_latch) & ~(ack_s & req_any);

  // coincident strobes reset, no chip select needed
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_cnt <= 8'h00;
      srst <= 1'b0;
    end
    else
    begin
      if (!both_low) rst_cnt <= 8'h00;
      else if (rst_cnt != 8'(RESET_CYCLES)) rst_cnt <= rst_cnt + 8'h01;
      srst <= both_low && (rst_cnt == 8'(RESET_CYCLES - 1) || rst_cnt == 8'(RESET_CYCLES));
    end
  end
  assign hw_reset = srst;

  always_comb
  begin
    next_state = state;
    case (state)
      shp_pkg::ACC_IDLE:
      begin
        if (rd_act) next_state = ack_s ? shp_pkg::ACC_ACK : shp_pkg::ACC_READ;
        else if (wr_act && !ack_s) next_state = shp_pkg::ACC_WRITE;
      end
      shp_pkg::ACC_READ, shp_pkg::ACC_ACK:
      begin
        if (!rd_act) next_state = shp_pkg::ACC_IDLE;
      end
      shp_pkg::ACC_WRITE:
      begin
        if (!wr_act) next_state = shp_pkg::ACC_IDLE;
      end
      default: next_state = shp_pkg::ACC_IDLE;
    endcase
    if (srst) next_state = shp_pkg::ACC_IDLE;
  end

  logic start, rd_end, wr_end;
  assign start = (state == shp_pkg::ACC_IDLE) && (next_state != shp_pkg::ACC_IDLE);
  assign rd_end = (state == shp_pkg::ACC_READ) && (next_state == shp_pkg::ACC_IDLE);
  assign wr_end = (state == shp_pkg::ACC_WRITE) && (next_state == shp_pkg::ACC_IDLE);

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst) state <= shp_pkg::ACC_IDLE;
    else state <= next_state;
  end

  // selects are only sampled at the start; the host keeps them steady
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      dc_l <= 1'b0;
      ch_a_l <= 1'b0;
      wdata <= 8'h00;
    end
    else
    begin
      if (start)
      begin
        dc_l <= dc_s;
        ch_a_l <= ab_s;
      end
      if (next_state == shp_pkg::ACC_WRITE) wdata <= din_s;
    end
  end

  logic [3:0] idx;
  assign idx = dc_l ? shp_pkg::REG_DATA : ptr;

  // read multiplexer, evaluated at strobe start
  function automatic logic [7:0] shp_read(input logic cha, input logic [3:0] i, input shp_pkg::shp_chan_in_t c,
      input logic [7:0] tl, input logic [7:0] th, input logic [7:0] xe, input logic [7:0] vec,
      input logic [5:0] ip, input logic [5:0] rq);
    logic [7:0] r;
    r = 8'h00;
    case (i)
      shp_pkg::REG_CMD: r = c.main;
      shp_pkg::REG_SPECIAL: r = c.special;
      shp_pkg::REG_VECTOR: r = cha ? vec : shp_vec_mod(vec, shp_code(rq));
      shp_pkg::REG_PENDING: r = cha ? {2'b00, ip} : 8'h00;
      shp_pkg::REG_FIFO_LO: r = c.fifo_lo;
      shp_pkg::REG_FIFO_HI: r = c.fifo_hi;
      shp_pkg::REG_DATA: r = c.rx_data;
      shp_pkg::REG_LOOP_CLK: r = c.loop & 8'hd2;
      shp_pkg::REG_TC_LO: r = tl;
      shp_pkg::REG_TC_HI: r = th;
      shp_pkg::REG_EXT_EN: r = xe;
      default: r = 8'h00;
    endcase
    return r;
  endfunction : shp_read

  logic [5:0] ip_en;
  logic dch;
  // readback shows the raw pending bits; master enable only gates requests
  assign ip_en = interrupt_pending_bit;
  assign dch = ab_s ? 1'b0 : 1'b1;
  assign claim = (state == shp_pkg::ACC_IDLE) && (next_state == shp_pkg::ACC_ACK) && req_any && iei_s;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      data_out <= 8'h00;
      data_oe <= 1'b0;
    end
    else
    begin
      if (next_state == shp_pkg::ACC_IDLE) data_oe <= 1'b0;
      if (start && next_state == shp_pkg::ACC_READ)
      begin
        data_out <= shp_read(ab_s, dc_s ? shp_pkg::REG_DATA : ptr, ab_s ? chan_a_in : chan_b_in,
          wreg[dch][shp_pkg::REG_TC_LO], wreg[dch][shp_pkg::REG_TC_HI], wreg[dch][shp_pkg::REG_EXT_EN],
          vec_reg, ip_en, req_vec);
        data_oe <= 1'b1;
      end
      if (claim && !mic_reg[shp_pkg::MIC_NV_BIT])
      begin
        data_out <= mic_reg[shp_pkg::MIC_VIS_BIT] ? shp_vec_mod(vec_reg, shp_code(req_vec)) : vec_reg;
        data_oe <= 1'b1;
      end
    end
  end

  // under-service latches: set on claim, cleared highest-first by command
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst) under_service_latch <= 6'h00;
    else if (srst) under_service_latch <= 6'h00;
    else if (claim) under_service_latch[shp_top(req_vec)] <= 1'b1;
    else if (wr_end && !dc_l && ptr == shp_pkg::REG_CMD &&
        wdata[5:shp_pkg::CMD_CODE_LSB] == shp_pkg::CMD_RESET_IUS && under_service_latch != 6'h00)
      under_service_latch[shp_top(under_service_latch)] <= 1'b0;
  end

  // pointer; a pointed access leaves it at zero, except a write with the pointer at zero, which loads it
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst) ptr <= shp_pkg::PTR_RESET;
    else if (srst) ptr <= shp_pkg::PTR_RESET;
    else if (wr_end && !dc_l && ptr == shp_pkg::REG_CMD)
      ptr <= {wdata[5:shp_pkg::CMD_CODE_LSB] == shp_pkg::CMD_POINT_HIGH, wdata[shp_pkg::CMD_PTR_MSB:0]};
    else if ((wr_end || rd_end) && !dc_l) ptr <= shp_pkg::PTR_RESET;
  end

  // write register file; vector and interrupt control live once
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      vec_reg <= shp_pkg::WREG_RESET;
      mic_reg <= shp_pkg::WREG_RESET;
      for (int c = 0; c < 2; c++)
        for (int r = 0; r < 16; r++)
          wreg[c][r] <= shp_pkg::WREG_RESET;
    end
    else if (srst)
    begin
      vec_reg <= shp_pkg::WREG_RESET;
      mic_reg <= shp_pkg::WREG_RESET;
      for (int c = 0; c < 2; c++)
        for (int r = 0; r < 16; r++)
          wreg[c][r] <= shp_pkg::WREG_RESET;
    end
    else if (wr_end && idx != shp_pkg::REG_CMD && idx != shp_pkg::REG_DATA)
    begin
      if (idx == shp_pkg::REG_VECTOR) vec_reg <= wdata;
      else if (idx == shp_pkg::REG_MASTER_INT) mic_reg <= wdata;
      else wreg[ch_a_l ? 1'b0 : 1'b1][idx] <= wdata;
    end
  end

  // engine-side strobes, one cycle each
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tx_load <= 2'b00;
      tx_data <= 8'h00;
      rx_take <= 2'b00;
      cfg_wr <= '0;
    end
    else
    begin
      tx_load <= 2'b00;
      rx_take <= 2'b00;
      cfg_wr.valid <= 1'b0;
      if (wr_end && idx == shp_pkg::REG_DATA)
      begin
        tx_load <= ch_a_l ? 2'b01 : 2'b10;
        tx_data <= wdata;
      end
      if (rd_end && idx == shp_pkg::REG_DATA) rx_take <= ch_a_l ? 2'b01 : 2'b10;
      if (wr_end && idx != shp_pkg::REG_CMD)
      begin
        cfg_wr.valid <= 1'b1;
        cfg_wr.chan_a <= ch_a_l;
        cfg_wr.idx <= idx;
        cfg_wr.data <= wdata;
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  ptr_clear_a: assert property ((rd_end || (wr_end && ptr != shp_pkg::REG_CMD)) && !dc_l && !srst
      |=> ptr == shp_pkg::PTR_RESET) else $error("pointer not cleared after pointed access");
  drive_gate_a: assert property (data_oe |-> $past(ce_s && rd_s)) else $error("data driven outside read");
  claim_cond_a: assert property ($rose(data_oe) && state == shp_pkg::ACC_ACK
      |-> $past(iei_s && req_any)) else $error("acknowledge claimed without chain input");
  ius_set_a: assert property (claim && !srst |=> under_service_latch != 6'h00) else $error("no under-service latch after claim");
  chain_out_a: assert property (under_service_latch != 6'h00 |-> !priority_chain_out) else $error("chain output high while in service");
  int_req_a: assert property (int_req_oe |-> mie && iei_s && interrupt_pending_bit != 6'h00)
    else $error("interrupt request without cause");
  hw_reset_a: assert property ($rose(srst) |-> $past(both_low) && $past(rst_cnt) >= 8'(RESET_CYCLES - 1))
    else $error("reset without long coincident strobes");
  tx_load_a: assert property (tx_load != 2'b00 |-> $past(wr_end) && $past(idx) == shp_pkg::REG_DATA)
    else $error("transmit load without data write");
  rx_take_a: assert property (rd_end && idx == shp_pkg::REG_DATA |=> rx_take != 2'b00)
    else $error("receive read did not take buffer");
endmodule : shp_host_port
`default_nettype wire

// ==== verification/shp_host_bfm.sv ====
`default_nettype none
module shp_host_bfm #(
  parameter int GAP_CYC = 25,
  parameter int HOLD_CYC = 8,
  parameter int SETTLE_CYC = 26
) (
  input wire logic clk,
  input wire logic data_oe,
  input wire logic [7:0] data_out,
  output logic ce_n,
  output logic rd_n,
  output logic wr_n,
  output logic data_sel,
  output logic chan_a_sel,
  output logic interrupt_acknowledge_n,
  output logic [7:0] drv_data
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    ce_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    data_sel = 1'b0;
    chan_a_sel = 1'b1;
    interrupt_acknowledge_n = 1'b1;
    drv_data = 8'h00;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  // selects and data outlive the strobe, then the line shows junk, not stale data
  task automatic release_bus();
    step(4);
    ce_n = 1'b1;
    interrupt_acknowledge_n = 1'b1;
    drv_data = ~drv_data;
    step(GAP_CYC);
  endtask : release_bus

  task automatic setup(input logic chan, input logic dsel, input logic cs);
    chan_a_sel = chan;
    data_sel = dsel;
    ce_n = ~cs;
    step(1);
  endtask : setup

  task automatic wait_answer(output logic [7:0] d, output logic ok);
    ok = 1'b0;
    d = 8'h00;
    for (int i = 0; i < 16 && !ok; i++)
    begin
      @(posedge clk);
      if (data_oe === 1'b1)
      begin
        ok = 1'b1;
        d = data_out;
      end
    end
    #1;
  endtask : wait_answer

  task automatic bus_write(input logic chan, input logic dsel, input logic [7:0] d);
    drv_data = d;
    setup(chan, dsel, 1'b1);
    wr_n = 1'b0;
    step(HOLD_CYC);
    wr_n = 1'b1;
    release_bus();
  endtask : bus_write

  task automatic bus_read(input logic chan, input logic dsel, input logic cs,
      output logic [7:0] d, output logic ok);
    setup(chan, dsel, cs);
    rd_n = 1'b0;
    wait_answer(d, ok);
    rd_n = 1'b1;
    release_bus();
  endtask : bus_read

  task automatic ack_read(output logic [7:0] d, output logic ok);
    interrupt_acknowledge_n = 1'b0;
    ce_n = 1'b0;
    step(SETTLE_CYC);
    rd_n = 1'b0;
    wait_answer(d, ok);
    rd_n = 1'b1;
    release_bus();
  endtask : ack_read

  task automatic strobe_reset(input int n);
    rd_n = 1'b0;
    wr_n = 1'b0;
    step(n);
    rd_n = 1'b1;
    wr_n = 1'b1;
    release_bus();
  endtask : strobe_reset
endmodule : shp_host_bfm
`default_nettype wire

// ==== verification/shp_host_port_tb.sv ====
`default_nettype none
module shp_host_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIMIT = 30000;
  logic clk;
  logic nrst;
  wire logic ce_n, rd_n, wr_n, data_sel, chan_a_sel, iack_n, data_oe, int_req_out, int_req_oe, hw_reset;
  wire logic priority_chain_out;
  logic priority_chain_in;
  wire logic [7:0] drv_data, data_out, tx_data, bus;
  wire logic [1:0] tx_load, rx_take;
  shp_pkg::shp_chan_in_t chan_a_in, chan_b_in;
  shp_pkg::shp_cfg_wr_t cfg_wr, cfg_last;
  logic [5:0] pend;
  logic [7:0] d, tx_last;
  logic ok;
  logic hw_seen = 1'b0;
  int err_count = 0, comparisons = 0, tx_a = 0, rx_a = 0, rx_b = 0, cyc = 0;
  logic [3:0] ridx [7] = '{shp_pkg::REG_SPECIAL, shp_pkg::REG_FIFO_LO, shp_pkg::REG_FIFO_HI,
      shp_pkg::REG_DATA, shp_pkg::REG_LOOP_CLK, 4'h4, shp_pkg::REG_PENDING};
  logic [7:0] rexp [7] = '{8'h42, 8'h66, 8'h77, 8'h5a, 8'hd2, 8'h00, 8'h00};

  assign bus = data_oe ? data_out : drv_data;

  shp_host_port #(.RESET_CYCLES(shp_pkg::RESET_CYC)) dut (.clk(clk), .nrst(nrst), .ce_n(ce_n), .rd_n(rd_n),
      .wr_n(wr_n), .data_sel(data_sel), .chan_a_sel(chan_a_sel), .interrupt_acknowledge_n(iack_n),
      .priority_chain_in(priority_chain_in), .priority_chain_out(priority_chain_out), .data_in(bus),
      .data_out(data_out), .data_oe(data_oe), .int_req_out(int_req_out), .int_req_oe(int_req_oe),
      .chan_a_in(chan_a_in), .chan_b_in(chan_b_in), .interrupt_pending_bit(pend), .tx_load(tx_load),
      .tx_data(tx_data), .rx_take(rx_take), .cfg_wr(cfg_wr), .hw_reset(hw_reset));

  shp_host_bfm host (.clk(clk), .data_oe(data_oe), .data_out(data_out), .ce_n(ce_n), .rd_n(rd_n),
      .wr_n(wr_n), .data_sel(data_sel), .chan_a_sel(chan_a_sel), .interrupt_acknowledge_n(iack_n),
      .drv_data(drv_data));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cfg_wr.valid === 1'b1) cfg_last <= cfg_wr;
    if (tx_load[0] === 1'b1) tx_last <= tx_data;
    if (tx_load[0] === 1'b1) tx_a <= tx_a + 1;
    if (rx_take[0] === 1'b1) rx_a <= rx_a + 1;
    if (rx_take[1] === 1'b1) rx_b <= rx_b + 1;
    if (hw_reset === 1'b1) hw_seen <= 1'b1;
    if (cyc == LIMIT)
    begin
      err_count++;
      $display("[ERR] run time expected under %0d cycles seen %0d", LIMIT, cyc);
      wrap_up();
    end
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic reg_wr(input logic chan, input logic [3:0] idx, input logic [7:0] v);
    if (idx != shp_pkg::REG_CMD) host.bus_write(chan, 1'b0, {2'b00, (idx[3] ? shp_pkg::CMD_POINT_HIGH : 3'h0), idx[2:0]});
    host.bus_write(chan, 1'b0, v);
  endtask : reg_wr

  task automatic reg_rd(input logic chan, input logic [3:0] idx, output logic [7:0] v);
    logic got;
    if (idx != shp_pkg::REG_CMD) host.bus_write(chan, 1'b0, {2'b00, (idx[3] ? shp_pkg::CMD_POINT_HIGH : 3'h0), idx[2:0]});
    host.bus_read(chan, 1'b0, 1'b1, v, got);
    check("read answered", {7'h00, got}, 8'h01);
  endtask : reg_rd

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : wrap_up

  initial
  begin
    nrst = 1'b0;
    priority_chain_in = 1'b1;
    pend = 6'h00;
    chan_a_in = 48'h81_42_ff_5a_66_77;
    chan_b_in = 48'h18_24_00_a5_99_88;
    repeat (20) @(posedge clk);
    #1;
    nrst = 1'b1;
    host.step(2);
    reg_rd(1'b1, shp_pkg::REG_CMD, d);
    check("status a", d, 8'h81);
    reg_rd(1'b0, shp_pkg::REG_CMD, d);
    check("status b", d, 8'h18);
    $display("test select done");
    host.bus_write(1'b1, 1'b1, 8'h3c);
    check("tx a pulses", 8'(tx_a), 8'h01);
    check("tx data", tx_last, 8'h3c);
    host.bus_read(1'b0, 1'b1, 1'b1, d, ok);
    check("rx b data", d, 8'ha5);
    check("rx b takes", 8'(rx_b), 8'h01);
    host.bus_read(1'b1, 1'b1, 1'b0, d, ok);
    check("answer without select", {7'h00, ok}, 8'h00);
    check("rx a takes", 8'(rx_a), 8'h00);
    $display("test direct done");
    reg_wr(1'b1, 4'h5, 8'hab);
    check("cfg idx", {4'h0, cfg_last.idx}, 8'h05);
    check("cfg data", cfg_last.data, 8'hab);
    check("cfg chan", {7'h00, cfg_last.chan_a}, 8'h01);
    host.bus_read(1'b1, 1'b0, 1'b1, d, ok);
    check("pointer cleared", d, 8'h81);
    for (int i = 0; i < 7; i++)
    begin
      reg_rd(1'b1, ridx[i], d);
      check("indirect read", d, rexp[i]);
    end
    $display("test pointer done");
    reg_wr(1'b1, shp_pkg::REG_TC_LO, 8'h34);
    reg_wr(1'b1, shp_pkg::REG_TC_HI, 8'h12);
    reg_rd(1'b1, shp_pkg::REG_TC_LO, d);
    check("tc low", d, 8'h34);
    reg_rd(1'b1, shp_pkg::REG_TC_HI, d);
    check("tc high", d, 8'h12);
    reg_rd(1'b0, shp_pkg::REG_TC_LO, d);
    check("tc low b", d, 8'h00);
    reg_wr(1'b0, shp_pkg::REG_VECTOR, 8'ha0);
    reg_rd(1'b1, shp_pkg::REG_VECTOR, d);
    check("vector a", d, 8'ha0);
    reg_rd(1'b0, shp_pkg::REG_VECTOR, d);
    check("vector b", d, {4'ha, shp_pkg::NO_INT_CODE, 1'b0});
    pend = 6'h2d;
    reg_rd(1'b1, shp_pkg::REG_PENDING, d);
    check("pending a", d, 8'h2d);
    reg_rd(1'b0, shp_pkg::REG_PENDING, d);
    check("pending b", d, 8'h00);
    $display("test registers done");
    pend = 6'h20;
    reg_wr(1'b1, 4'h4, 8'h44);
    reg_wr(1'b0, shp_pkg::REG_MASTER_INT, 8'h09);
    reg_wr(1'b1, 4'h1, 8'h13);
    host.step(6);
    check("irq drive", {7'h00, int_req_oe}, 8'h01);
    check("irq level", {7'h00, int_req_out}, 8'h00);
    priority_chain_in = 1'b0;
    host.step(6);
    check("irq chain low", {7'h00, int_req_oe}, 8'h00);
    priority_chain_in = 1'b1;
    host.step(6);
    host.ack_read(d, ok);
    check("ack claimed", {7'h00, ok}, 8'h01);
    check("ack vector", d, {4'ha, 3'h6, 1'b0});
    check("chain out served", {7'h00, priority_chain_out}, 8'h00);
    host.bus_write(1'b1, 1'b0, {2'b00, shp_pkg::CMD_RESET_IUS, 3'h0});
    check("chain out free", {7'h00, priority_chain_out}, 8'h01);
    reg_wr(1'b0, shp_pkg::REG_MASTER_INT, 8'h0a);
    host.ack_read(d, ok);
    check("ack no vector", {7'h00, ok}, 8'h00);
    check("chain out no vector", {7'h00, priority_chain_out}, 8'h00);
    host.bus_write(1'b1, 1'b0, {2'b00, shp_pkg::CMD_RESET_IUS, 3'h0});
    priority_chain_in = 1'b0;
    host.step(6);
    host.ack_read(d, ok);
    check("ack unclaimed", {7'h00, ok}, 8'h00);
    priority_chain_in = 1'b1;
    $display("test interrupt done");
    // just under the coincident-low threshold must leave state alone
    host.strobe_reset(shp_pkg::RESET_CYC - 5);
    check("short coincident", {7'h00, hw_seen}, 8'h00);
    host.strobe_reset(shp_pkg::RESET_CYC + 5);
    check("reset seen", {7'h00, hw_seen}, 8'h01);
    check("reset ends", {7'h00, hw_reset}, 8'h00);
    reg_rd(1'b1, shp_pkg::REG_VECTOR, d);
    check("vector cleared", d, 8'h00);
    reg_rd(1'b1, shp_pkg::REG_TC_LO, d);
    check("tc cleared", d, 8'h00);
    check("irq after reset", {7'h00, int_req_oe}, 8'h00);
    $display("test strobe reset done");
    wrap_up();
  end
endmodule : shp_host_port_tb
`default_nettype wire
